/* File: design/flash_host_regs.svh */
/*
  Register offsets, status bit positions, flash command bytes and timing counts
  for the parallel flash host controller.
  Assumes a 50 MHz clock and a byte-wide flash with 19 address lines.
*/
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// Register offsets on the software port
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ADDR 8'h08
`define REG_BUF_INDEX 8'h0C
`define REG_BUF_DATA 8'h10
`define REG_RDATA 8'h14

// Status bit positions
`define ST_BUSY 0
`define ST_DONE 1
`define ST_TIMEOUT 2
`define ST_REFUSED 3
`define ST_POWER_OK 4

// Flash geometry
`define ADDR_W 19
`define SECTOR_BYTES 256
`define LAST_BYTE 8'hFF
`define POLL_TOGGLE_BIT 6
`define POLL_DATA_BIT 7

// Command addresses and data bytes
`define CMD_ADDR_A 19'h05555
`define CMD_ADDR_B 19'h02AAA
`define CMD_BOOT_LO 19'h00000
`define CMD_BOOT_HI 19'h7FFFF
`define CMD_D_AA 8'hAA
`define CMD_D_55 8'h55
`define CMD_D_PROG 8'hA0
`define CMD_D_EXT 8'h80
`define CMD_D_ID_IN 8'h90
`define CMD_D_ID_OUT 8'hF0
`define CMD_D_ERASE 8'h10
`define CMD_D_LOCK 8'h40
`define CMD_D_LOCK_SET 8'hFF
`define CMD_LEN_SHORT 3'd3
`define CMD_LEN_ERASE 3'd6
`define CMD_LEN_LOCK 3'd7

// Timing, printed figures and derived cycle counts
`define CLK_PERIOD_NS 20
`define T_WP_NS 200
`define T_WPH_NS 200
`define T_ACC_NS 150
`define T_OEHP_NS 150
`define T_BLC_US 150
`define T_WC_MS 20
`define T_PWRUP_MS 10
`define WP_CYCLES ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WPH_CYCLES ((`T_WPH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACC_CYCLES ((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OEHP_CYCLES ((`T_OEHP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLC_CYCLES ((`T_BLC_US * 1000) / `CLK_PERIOD_NS)
`define WC_CYCLES ((`T_WC_MS * 1000000) / `CLK_PERIOD_NS)
`define PWRUP_CYCLES ((`T_PWRUP_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: design/flash_host_pkg.sv */
/*
  Types for the parallel flash host controller: operation codes and states.
  Assumes nothing of its surroundings.
*/
package flash_host_pkg;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_ERASE = 3'h2,
    OP_ID_ENTER = 3'h3,
    OP_ID_EXIT = 3'h4,
    OP_LOCK_LO = 3'h5,
    OP_LOCK_HI = 3'h6
  } op_e;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_SCRIPT = 3'b001,
    HS_LOAD = 3'b011,
    HS_POLL = 3'b010,
    HS_READ = 3'b110
  } host_state_e;

  typedef enum logic [2:0] {
    CY_IDLE = 3'b000,
    CY_SETUP = 3'b001,
    CY_STROBE = 3'b011,
    CY_HOLD = 3'b010,
    CY_RECOVER = 3'b110
  } cyc_state_e;

endpackage : flash_host_pkg

/* File: design/pin_cycle.sv */
/*
  One timed flash bus cycle (byte write or byte read) on the flash pins.
  Assumes the caller starts a cycle only while done is not pending and that
  data_in is synchronous to clk.
*/
`timescale 1ns/10ps
`include "flash_host_regs.svh"

module pin_cycle
  import flash_host_pkg::*;
#(
  parameter int WP_CYC = `WP_CYCLES,
  parameter int WPH_CYC = `WPH_CYCLES,
  parameter int ACC_CYC = `ACC_CYCLES,
  parameter int OEHP_CYC = `OEHP_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic is_write,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] data_in,
  output logic [`ADDR_W-1:0] address_lines,
  output logic chip_select_n,
  output logic output_gate_n,
  output logic write_strobe_n,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic [7:0] rdata,
  output logic done
);

  cyc_state_e state, next_state;
  logic wr, next_wr;
  logic [4:0] cnt, next_cnt;
  logic [`ADDR_W-1:0] next_address_lines;
  logic next_chip_select_n, next_output_gate_n, next_write_strobe_n;
  logic [7:0] next_data_out, next_rdata;
  logic next_data_oe, next_done;

  always_comb begin
    next_state = state;
    next_wr = wr;
    next_cnt = cnt;
    next_address_lines = address_lines;
    next_chip_select_n = chip_select_n;
    next_output_gate_n = output_gate_n;
    next_write_strobe_n = write_strobe_n;
    next_data_out = data_out;
    next_data_oe = data_oe;
    next_rdata = rdata;
    next_done = 1'b0;
    case (state)
      CY_IDLE: begin
        if (start) begin
          next_wr = is_write;
          next_address_lines = addr;
          next_data_out = wdata;
          next_state = CY_SETUP;
        end
      end
      CY_SETUP: begin
        // Both strobes fall together, so address latches on this edge
        next_chip_select_n = 1'b0;
        if (wr) begin
          next_write_strobe_n = 1'b0;
          next_data_oe = 1'b1;
          next_cnt = 5'(WP_CYC - 1);
        end else begin
          next_output_gate_n = 1'b0;
          next_cnt = 5'(ACC_CYC - 1);
        end
        next_state = CY_STROBE;
      end
      CY_STROBE: begin
        if (cnt == 5'h00) begin
          next_chip_select_n = 1'b1;
          next_write_strobe_n = 1'b1;
          next_output_gate_n = 1'b1;
          if (!wr) begin
            next_rdata = data_in;
          end
          next_state = CY_HOLD;
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end
      CY_HOLD: begin
        // Data stays one cycle past the rising strobe for hold time
        next_data_oe = 1'b0;
        next_cnt = wr ? 5'(WPH_CYC - 1) : 5'(OEHP_CYC - 1);
        next_state = CY_RECOVER;
      end
      CY_RECOVER: begin
        if (cnt == 5'h00) begin
          next_done = 1'b1;
          next_state = CY_IDLE;
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end
      default: next_state = CY_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= CY_IDLE;
      wr <= 1'b0;
      cnt <= 5'h00;
      address_lines <= '0;
      chip_select_n <= 1'b1;
      output_gate_n <= 1'b1;
      write_strobe_n <= 1'b1;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      rdata <= 8'h00;
      done <= 1'b0;
    end else begin
      state <= next_state;
      wr <= next_wr;
      cnt <= next_cnt;
      address_lines <= next_address_lines;
      chip_select_n <= next_chip_select_n;
      output_gate_n <= next_output_gate_n;
      write_strobe_n <= next_write_strobe_n;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      rdata <= next_rdata;
      done <= next_done;
    end
  end

endmodule : pin_cycle

/* File: design/flash_host.sv */
/*
  Host controller for a sector-programmed parallel flash: byte reads, sector
  program with unlock sequence, chip erase, identification entry and exit,
  boot-block lockout, and completion polling. Software uses a simple
  register port with read data one cycle after the read strobe.
  Assumes the flash pins are wired directly and data_in is synchronous.
*/
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "flash_host_regs.svh"

// Operation
// - Sector is 256 bytes, always load all
// - Every program starts with three-command unlock
// - Byte load strobes with output gate high
// - Next byte strobe within 150 us
// - Sector bits fixed, byte bits any order
// - Lockout needs seven fixed program commands
module flash_host
  import flash_host_pkg::*;
#(
  parameter int WC_CYCLES = `WC_CYCLES,
  parameter int PWRUP_CYCLES = `PWRUP_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [`ADDR_W-1:0] address_lines,
  output logic chip_select_n,
  output logic output_gate_n,
  output logic write_strobe_n,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] data_in
);

  // Command step table: address and data for step idx of an operation
  function automatic logic [`ADDR_W+7:0] cmd_step(input op_e op, input logic [2:0] idx);
    logic [7:0] third;
    third = `CMD_D_EXT;
    case (op)
      OP_PROGRAM: third = `CMD_D_PROG;
      OP_ID_ENTER: third = `CMD_D_ID_IN;
      OP_ID_EXIT: third = `CMD_D_ID_OUT;
      default: third = `CMD_D_EXT;
    endcase
    case (idx)
      3'd0: cmd_step = {`CMD_ADDR_A, `CMD_D_AA};
      3'd1: cmd_step = {`CMD_ADDR_B, `CMD_D_55};
      3'd2: cmd_step = {`CMD_ADDR_A, third};
      3'd3: cmd_step = {`CMD_ADDR_A, `CMD_D_AA};
      3'd4: cmd_step = {`CMD_ADDR_B, `CMD_D_55};
      3'd5: cmd_step = {`CMD_ADDR_A, (op == OP_ERASE) ? `CMD_D_ERASE : `CMD_D_LOCK};
      3'd6: cmd_step = {(op == OP_LOCK_HI) ? `CMD_BOOT_HI : `CMD_BOOT_LO, `CMD_D_LOCK_SET};
      default: cmd_step = {`CMD_ADDR_A, `CMD_D_AA};
    endcase
  endfunction : cmd_step

  function automatic logic [2:0] script_len(input op_e op);
    case (op)
      OP_ERASE: script_len = `CMD_LEN_ERASE;
      OP_LOCK_LO, OP_LOCK_HI: script_len = `CMD_LEN_LOCK;
      default: script_len = `CMD_LEN_SHORT;
    endcase
  endfunction : script_len

  logic [7:0] sector_buf [0:`SECTOR_BYTES-1];

  host_state_e state, next_state;
  op_e op, next_op;
  logic [`ADDR_W-1:0] target, next_target, poll_addr, next_poll_addr;
  logic [7:0] buf_index, next_buf_index, load_idx, next_load_idx;
  logic [2:0] step, next_step;
  logic pending, next_pending, poll_first, next_poll_first, prev_b6, next_prev_b6;
  logic check_b7, next_check_b7, exp_b7, next_exp_b7;
  logic [31:0] tmo_cnt, next_tmo_cnt, pwr_cnt, next_pwr_cnt;
  logic power_ok, next_power_ok;
  logic done_f, next_done_f, tmo_f, next_tmo_f, ref_f, next_ref_f;
  logic [7:0] last_rdata, next_last_rdata;
  logic [31:0] next_reg_rdata;
  logic buf_we;
  logic cyc_start, cyc_write, cyc_done;
  logic [`ADDR_W-1:0] cyc_addr;
  logic [7:0] cyc_wdata, cyc_rdata;
  logic [`ADDR_W+7:0] step_word;
  logic is_idle;

  assign is_idle = (state == HS_IDLE);
  assign step_word = cmd_step(op, step);

  always_comb begin
    next_state = state;
    next_op = op;
    next_target = target;
    next_poll_addr = poll_addr;
    next_buf_index = buf_index;
    next_load_idx = load_idx;
    next_step = step;
    next_pending = pending;
    next_poll_first = poll_first;
    next_prev_b6 = prev_b6;
    next_check_b7 = check_b7;
    next_exp_b7 = exp_b7;
    next_tmo_cnt = tmo_cnt;
    next_pwr_cnt = pwr_cnt;
    next_power_ok = power_ok;
    next_done_f = done_f;
    next_tmo_f = tmo_f;
    next_ref_f = ref_f;
    next_last_rdata = last_rdata;
    next_reg_rdata = 32'h0000_0000;
    buf_we = 1'b0;
    cyc_start = 1'b0;
    cyc_write = 1'b0;
    cyc_addr = target;
    cyc_wdata = 8'h00;

    // No commands until the flash has passed its power-on lockout
    if (!power_ok) begin
      if (pwr_cnt == 32'(PWRUP_CYCLES - 1)) begin
        next_power_ok = 1'b1;
      end else begin
        next_pwr_cnt = pwr_cnt + 32'h1;
      end
    end

    // Software port
    if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL: begin
          if (!is_idle || !power_ok || reg_wdata[2:0] == 3'h7) begin
            next_ref_f = 1'b1;
          end else begin
            next_op = op_e'(reg_wdata[2:0]);
            next_done_f = 1'b0;
            next_tmo_f = 1'b0;
            next_ref_f = 1'b0;
            next_step = 3'd0;
            next_pending = 1'b0;
            next_state = (reg_wdata[2:0] == OP_READ) ? HS_READ : HS_SCRIPT;
          end
        end
        `REG_ADDR: if (is_idle) next_target = reg_wdata[`ADDR_W-1:0];
        `REG_BUF_INDEX: if (is_idle) next_buf_index = reg_wdata[7:0];
        `REG_BUF_DATA: begin
          if (is_idle) begin
            buf_we = 1'b1;
            next_buf_index = buf_index + 8'h01;
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `REG_STATUS: begin
          next_reg_rdata[`ST_BUSY] = !is_idle;
          next_reg_rdata[`ST_DONE] = done_f;
          next_reg_rdata[`ST_TIMEOUT] = tmo_f;
          next_reg_rdata[`ST_REFUSED] = ref_f;
          next_reg_rdata[`ST_POWER_OK] = power_ok;
        end
        `REG_CTRL: next_reg_rdata[2:0] = op;
        `REG_ADDR: next_reg_rdata[`ADDR_W-1:0] = target;
        `REG_BUF_INDEX: next_reg_rdata[7:0] = buf_index;
        `REG_BUF_DATA: next_reg_rdata[7:0] = sector_buf[buf_index];
        `REG_RDATA: next_reg_rdata[7:0] = last_rdata;
        default: ;
      endcase
    end

    case (state)
      HS_IDLE: ;
      HS_SCRIPT: begin
        cyc_write = 1'b1;
        {cyc_addr, cyc_wdata} = step_word;
        cyc_start = !pending;
        if (!pending) next_pending = 1'b1;
        if (cyc_done) begin
          next_pending = 1'b0;
          if (step == script_len(op) - 3'd1) begin
            next_tmo_cnt = 32'h0;
            next_poll_first = 1'b1;
            next_poll_addr = target;
            next_check_b7 = 1'b0;
            next_load_idx = 8'h00;
            case (op)
              OP_PROGRAM: next_state = HS_LOAD;
              OP_ERASE, OP_LOCK_LO, OP_LOCK_HI: next_state = HS_POLL;
              default: begin
                next_done_f = 1'b1;
                next_state = HS_IDLE;
              end
            endcase
          end else begin
            next_step = step + 3'd1;
          end
        end
      end
      HS_LOAD: begin
        // Sector bits fixed for the whole load; gaps stay far below the window
        cyc_write = 1'b1;
        cyc_addr = {target[`ADDR_W-1:8], load_idx};
        cyc_wdata = sector_buf[load_idx];
        cyc_start = !pending;
        if (!pending) next_pending = 1'b1;
        if (cyc_done) begin
          next_pending = 1'b0;
          if (load_idx == `LAST_BYTE) begin
            next_poll_addr = cyc_addr;
            next_exp_b7 = cyc_wdata[`POLL_DATA_BIT];
            next_check_b7 = 1'b1;
            next_state = HS_POLL;
          end else begin
            next_load_idx = load_idx + 8'h01;
          end
        end
      end
      HS_POLL: begin
        // Poll the last loaded byte after a program, or target after erase or lockout, until bit 6 stops toggling and, after a program, bit 7 matches the byte
        cyc_addr = poll_addr;
        cyc_start = !pending;
        if (!pending) next_pending = 1'b1;
        if (tmo_cnt != 32'(WC_CYCLES)) next_tmo_cnt = tmo_cnt + 32'h1;
        if (cyc_done) begin
          next_pending = 1'b0;
          next_last_rdata = cyc_rdata;
          next_prev_b6 = cyc_rdata[`POLL_TOGGLE_BIT];
          next_poll_first = 1'b0;
          if (!poll_first && prev_b6 == cyc_rdata[`POLL_TOGGLE_BIT] &&
              (!check_b7 || cyc_rdata[`POLL_DATA_BIT] == exp_b7)) begin
            next_done_f = 1'b1;
            next_state = HS_IDLE;
          end else if (tmo_cnt == 32'(WC_CYCLES)) begin
            next_tmo_f = 1'b1;
            next_state = HS_IDLE;
          end
        end
      end
      HS_READ: begin
        cyc_start = !pending;
        if (!pending) next_pending = 1'b1;
        if (cyc_done) begin
          next_pending = 1'b0;
          next_last_rdata = cyc_rdata;
          next_done_f = 1'b1;
          next_state = HS_IDLE;
        end
      end
      default: next_state = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (buf_we) begin
      sector_buf[buf_index] <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= HS_IDLE;
      op <= OP_READ;
      target <= '0;
      poll_addr <= '0;
      buf_index <= 8'h00;
      load_idx <= 8'h00;
      step <= 3'd0;
      pending <= 1'b0;
      poll_first <= 1'b1;
      prev_b6 <= 1'b0;
      check_b7 <= 1'b0;
      exp_b7 <= 1'b0;
      tmo_cnt <= 32'h0;
      pwr_cnt <= 32'h0;
      power_ok <= 1'b0;
      done_f <= 1'b0;
      tmo_f <= 1'b0;
      ref_f <= 1'b0;
      last_rdata <= 8'h00;
      reg_rdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      op <= next_op;
      target <= next_target;
      poll_addr <= next_poll_addr;
      buf_index <= next_buf_index;
      load_idx <= next_load_idx;
      step <= next_step;
      pending <= next_pending;
      poll_first <= next_poll_first;
      prev_b6 <= next_prev_b6;
      check_b7 <= next_check_b7;
      exp_b7 <= next_exp_b7;
      tmo_cnt <= next_tmo_cnt;
      pwr_cnt <= next_pwr_cnt;
      power_ok <= next_power_ok;
      done_f <= next_done_f;
      tmo_f <= next_tmo_f;
      ref_f <= next_ref_f;
      last_rdata <= next_last_rdata;
      reg_rdata <= next_reg_rdata;
    end
  end

  // Output gate stays high through every write strobe
  pin_cycle u_pin_cycle (
    .clk(clk),
    .resetn(resetn),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .data_in(data_in),
    .address_lines(address_lines),
    .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n),
    .write_strobe_n(write_strobe_n),
    .data_out(data_out),
    .data_oe(data_oe),
    .rdata(cyc_rdata),
    .done(cyc_done)
  );

endmodule : flash_host

/* File: tb/flash_host_sva.sv */
/*
  Pin-level checker for the flash host controller.
  Assumes a single clk domain and the synchronous active-low resetn.
*/
`timescale 1ns/10ps
`include "flash_host_regs.svh"
module flash_host_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [`ADDR_W-1:0] address_lines,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_we_low10;
    !write_strobe_n [*8] ##1 !write_strobe_n [*2];
  endsequence
  sequence s_we_high10;
    write_strobe_n [*8] ##1 write_strobe_n [*2];
  endsequence
  sequence s_read_pulse;
    (!output_gate_n && !chip_select_n && write_strobe_n) [*7] ##[1:2] output_gate_n;
  endsequence
  AST_WE_PULSE: assert property ($fell(write_strobe_n) |-> s_we_low10 ##1 write_strobe_n)
    else $error("write pulse not ten cycles");
  AST_WE_RECOVER: assert property ($rose(write_strobe_n) |-> s_we_high10)
    else $error("write strobe high time too short");
  AST_WE_QUAL: assert property (!write_strobe_n |-> !chip_select_n && output_gate_n && data_oe)
    else $error("write strobe without select, gate high and data");
  AST_GATE_QUAL: assert property (!output_gate_n |-> write_strobe_n && !data_oe)
    else $error("output gate low while writing or driving");
  AST_READ_PULSE: assert property ($fell(output_gate_n) |-> s_read_pulse)
    else $error("read pulse malformed");
  AST_ADDR_HOLD: assert property (!chip_select_n |-> $stable(address_lines))
    else $error("address moved during a cycle");
  AST_DATA_HOLD: assert property ($rose(write_strobe_n) |-> data_oe && $stable(data_out))
    else $error("data not held at strobe rise");
  AST_GATE_HIGH: assert property ($rose(output_gate_n) |-> output_gate_n [*8])
    else $error("output gate high pulse too short");
  AST_RESET_IDLE: assert property (disable iff (1'b0) !resetn |=>
    chip_select_n && write_strobe_n && output_gate_n && !data_oe)
    else $error("pins not idle in reset");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule : flash_host_sva

bind flash_host flash_host_sva flash_host_sva_i (.clk(clk), .resetn(resetn), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .address_lines(address_lines), .chip_select_n(chip_select_n),
  .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n), .data_out(data_out),
  .data_oe(data_oe));

/* File: tb/flash_model.sv */
/*
  Behavioural parallel flash on the far side of the host pins.
  Assumes pins change on clk; all device timers count clk cycles.
*/
`timescale 1ns/10ps
module flash_model #(
  parameter int BLC = 100,
  parameter int WCM = 100,
  parameter logic [7:0] MAKER = 8'h3A, // Arbitrary code
  parameter logic [7:0] PART = 8'h5C // Arbitrary code
) (
  input wire logic clk,
  input wire logic [18:0] address_lines,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic [7:0] data_in
);
  localparam int U1 = 32'h05555AA;
  localparam int U2 = 32'h02AAA55;
  logic [7:0] mem [int];
  logic [7:0] ld [int];
  int hist[$];
  int busy = 0, load_t = 0, sec = 0;
  logic [18:0] a_lat = 19'h00000;
  logic [7:0] last_d = 8'hFF, q = 8'hFF;
  logic wr_d = 1'b0, rd_d = 1'b0, prog = 1'b0, idm = 1'b0, lk_lo = 1'b0, lk_hi = 1'b0, tog = 1'b0;
  wire wr = !chip_select_n && !write_strobe_n && output_gate_n;
  wire rd = !chip_select_n && !output_gate_n && write_strobe_n;
  initial data_in = 8'h00;
  function automatic bit tail(input int p[$]);
    if (hist.size() < p.size()) return 0;
    foreach (p[i]) if (hist[hist.size() - p.size() + i] != p[i]) return 0;
    return 1;
  endfunction : tail
  task automatic commit();
    prog = 1'b0;
    busy = WCM;
    if ((lk_lo && sec < 64) || (lk_hi && sec >= 1984)) return;
    for (int i = 0; i < 256; i++) mem[sec * 256 + i] = ld.exists(i) ? ld[i] : 8'hFF;
  endtask : commit
  task automatic take(input int a, input logic [7:0] d);
    if (prog) begin
      ld[a % 256] = d;
      sec = a / 256;
      load_t = BLC;
      last_d = d;
      return;
    end
    hist.push_back(a * 256 + d);
    if (hist.size() > 7) void'(hist.pop_front());
    if (tail('{U1, U2, 32'h0555580, U1, U2, 32'h0555540, 32'h00000FF})) lk_lo = 1'b1;
    else if (tail('{U1, U2, 32'h0555580, U1, U2, 32'h0555540, 32'h7FFFFFF})) lk_hi = 1'b1;
    else if (tail('{U1, U2, 32'h0555580, U1, U2, 32'h0555510})) begin
      if (!lk_lo && !lk_hi) mem.delete();
    end
    else if (tail('{U1, U2, 32'h05555A0})) prog = 1'b1;
    else if (tail('{U1, U2, 32'h0555590})) idm = 1'b1;
    else if (tail('{U1, U2, 32'h05555F0})) idm = 1'b0;
    else if (a != 32'h5555 && a != 32'h2AAA) begin
      busy = WCM;
      last_d = d;
    end
    if (tail('{32'h00000FF}) || tail('{32'h7FFFFFF}) || tail('{32'h0555510})) begin
      busy = WCM;
      last_d = 8'hFF;
    end
    if (prog) ld.delete();
    if (hist.size() > 0 && (prog || tail('{U1, U2, 32'h0555590}))) hist.delete();
  endtask : take
  always @(posedge clk) begin
    if (wr && !wr_d) a_lat = address_lines;
    if (!wr && wr_d) take(int'(a_lat), data_out);
    if (prog && !wr && load_t > 0) begin
      load_t--;
      if (load_t == 0) commit();
    end
    if (rd && !rd_d) begin
      tog = !tog;
      // Load window already counts as a running program cycle
      if (busy > 0 || prog) q = {~last_d[7], tog, last_d[5:0]};
      else if (idm) begin
        case (address_lines)
          19'h00000: q = MAKER;
          19'h00001: q = PART;
          19'h00002: q = lk_lo ? 8'hFF : 8'hFE;
          19'h7FFF2: q = lk_hi ? 8'hFF : 8'hFE;
          default: q = 8'hFF;
        endcase
      end
      else q = mem.exists(int'(address_lines)) ? mem[int'(address_lines)] : 8'hFF;
    end
    if (busy > 0) busy--;
    wr_d = wr;
    rd_d = rd;
    // Released lines invert every cycle, so the old byte shows only on alternate cycles
    data_in <= data_oe ? data_out : (rd ? q : ~data_in);
  end
endmodule : flash_model

/* File: tb/flash_host_tb.sv */
/*
  Self-checking bench: flash host controller against a behavioural flash.
  Assumes the register map of the controller header and its op codes.
*/
`timescale 1ns/10ps
`include "flash_host_regs.svh"
module flash_host_tb;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER = 8'h3A; // Arbitrary code
  localparam logic [7:0] PART = 8'h5C; // Arbitrary code
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, st;
  logic [18:0] address_lines;
  logic chip_select_n, output_gate_n, write_strobe_n, data_oe;
  logic [7:0] data_out, data_in;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 37771;
  logic [7:0] exp_mem [int];
  always #10 clk = ~clk;
  flash_host #(.WC_CYCLES(20000), .PWRUP_CYCLES(20)) flash_host_i (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .address_lines(address_lines), .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in));
  flash_model #(.MAKER(MAKER), .PART(PART)) flash_model_i (.clk(clk),
    .address_lines(address_lines), .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
    .write_strobe_n(write_strobe_n), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // Gap cycle after each strobe so no strobe is assigned twice per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic run_op(input op_e op);
    wr(`REG_CTRL, {29'h0, op});
    for (int n = 0; n < 20000; n++) begin
      rd(`REG_STATUS, st);
      if (st[`ST_BUSY] === 1'b0) break;
    end
    if (st[`ST_BUSY] !== 1'b0) begin
      mismatches++;
      finish_test();
    end
  endtask : run_op
  task automatic frd(input int a, input logic [7:0] want);
    logic [31:0] v;
    wr(`REG_ADDR, 32'(a));
    run_op(OP_READ);
    rd(`REG_RDATA, v);
    chk(v, {24'h0, want});
  endtask : frd
  function automatic logic [7:0] ex(input int a);
    return exp_mem.exists(a) ? exp_mem[a] : 8'hFF;
  endfunction : ex
  task automatic prog(input int sec);
    logic [7:0] v;
    wr(`REG_BUF_INDEX, 32'h0);
    for (int i = 0; i < 256; i++) begin
      v = 8'($random(seed));
      exp_mem[sec * 256 + i] = v;
      wr(`REG_BUF_DATA, {24'h0, v});
    end
    wr(`REG_ADDR, 32'(sec * 256));
    run_op(OP_PROGRAM);
  endtask : prog
  initial begin
    #2000000;
    mismatches++;
    finish_test();
  end
  initial begin
    int a;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    run_op(OP_PROGRAM);
    chk(st & 32'h18, 32'h08);
    for (int n = 0; n < 100 && st[`ST_POWER_OK] !== 1'b1; n++) rd(`REG_STATUS, st);
    chk({31'h0, st[`ST_POWER_OK]}, 32'h1);
    rd(8'h20, st);
    chk(st, 32'h0);
    $display("test power and map done");
    prog(291);
    chk(st & 32'h1E, 32'h12);
    prog(291);
    chk(st & 32'h1E, 32'h12);
    for (int i = 0; i < 6; i++) begin
      a = 291 * 256 + ($random(seed) & 255);
      frd(a, ex(a));
    end
    frd(291 * 256 + 255, ex(291 * 256 + 255));
    wr(`REG_CTRL, 32'h0);
    run_op(OP_READ);
    chk(st & 32'h8, 32'h8);
    $display("test program done");
    run_op(OP_ERASE);
    exp_mem.delete();
    frd(a, 8'hFF);
    $display("test erase done");
    prog(0);
    run_op(OP_LOCK_LO);
    run_op(OP_ID_ENTER);
    frd(0, MAKER);
    frd(1, PART);
    frd(2, 8'hFF);
    frd(32'h7FFF2, 8'hFE);
    run_op(OP_ID_EXIT);
    run_op(OP_ERASE);
    frd(5, ex(5));
    $display("test lockout done");
    finish_test();
  end
endmodule : flash_host_tb
